// *** core/status_register_spi_readout.sv ***
// Serial status read-out port with latched flags and mode forcing
// Summary of operation
// (RULE_01) Chip select high: ignore clock, output tri-stated
// (RULE_02) Shift next bit out on clock rising edge
// (RULE_03) Host clocks between 10 kbit/s and 2 Mbit/s; the bench host clocks at 5 Mbit/s
// (RULE_04) Read-out starts at bit zero, ascending order
// (RULE_05) Falling-edge count not 16 flags frame error
// (RULE_06) Good frame end clears inactive latched bits
// (RULE_07) 32-clock frame reads version, counts as error
// (RULE_08) Bits 24 to 31 carry digital revision
// (RULE_09) Bits 16 to 23 carry analog revision
// (RULE_10) Port works only latched mode, io supply good
// (RULE_11) Port disabled below main supply power-on threshold
// (RULE_12) Wake, mode, ready bits mirror flags directly
// (RULE_13) Bit 3 samples guardian pin at bit 2 fall; code reads bit 3 low in standby mode
// (RULE_14) Bits 4 to 10 latch high flag levels
// (RULE_15) Bits 11,13 read low; 12,14 read high
// (RULE_16) Bit 15 is XOR of bits 0 to 14
// (RULE_17) Under-voltage flag forces standby over control input
// (RULE_18) After under-voltage clears, follow standby control input
// (RULE_19) Wake flag clears under-voltage flags, stays standby; code follows standby control input once flags clear
// (RULE_20) Clock not low at select edge is frame error
// (RULE_21) Frame error flag clears on select fall or track
`timescale 1ns/10ps
`default_nettype none
`include "status_spi_map.svh"

module status_register_spi_readout #(
    parameter logic [7:0] ANALOG_REV  = 8'h11,  // Arbitrary value
    parameter logic [7:0] DIGITAL_REV = 8'h22   // Arbitrary value
) (
    input  wire logic clk,                      // 40 MHz system clock
    input  wire logic rst_n,                    // Synchronous reset, active low
    input  wire logic csn_pin,                  // Chip select from host, active low
    input  wire logic sck_pin,                  // Serial clock from host
    output logic      sdo_o,                    // Serial data out
    output logic      sdo_oe,                   // Serial data output enable
    input  wire logic standby_control_input,    // Low requests standby
    input  wire logic guardian_enable_input,    // Guardian enable pin
    input  wire logic track_mode,               // Track error-indication mode selected
    input  wire logic main_supply_power_on_threshold, // High when main supply above threshold
    input  wire logic wake_flag,                // Remote wakeup flag
    input  wire logic tx_ready_flag,            // Transmitter ready flag
    input  wire logic power_on_flag,            // Power-on flag
    input  wire logic bus_error_flag,           // Bus error flag
    input  wire logic thermal_flag,             // Thermal shutdown flag
    input  wire logic tx_timeout_flag,          // Transmit-enable timeout flag
    input  wire logic main_uv_detect,           // Main supply under-voltage detected
    input  wire logic io_uv_detect,             // IO supply under-voltage detected
    output logic      main_uv_flag,             // Main supply under-voltage flag
    output logic      io_uv_flag,               // IO supply under-voltage flag
    output logic      normal_mode,              // High in normal mode
    output logic      frame_error_flag,         // Internal serial frame error flag
    output logic [6:0] latched_status           // Latched status bits 4 to 10
);

    // Synchronisers: first stage read only by the second
    logic [1:0] csn_sync_reg;
    logic [1:0] sck_sync_reg;
    logic       csn_d_reg;
    logic       sck_d_reg;
    logic       csn_fall;
    logic       csn_rise;
    logic       sck_rise;
    logic       sck_fall;
    logic       csn_s;
    logic       sck_s;

    status_spi_pkg::op_mode_e mode_reg;
    logic [5:0]  fall_cnt_reg;
    logic        frame_bad_reg;
    logic [4:0]  bit_idx_reg;
    logic        guard_fb_reg;
    logic        port_on;
    logic [31:0] word;
    logic [6:0]  live_flags;
    logic        mode_is_normal;

    // A frame is correct with sixteen falls and the clock low at both select edges
    function automatic logic frame_ok(input logic [5:0] falls,
                                      input logic       bad_start,
                                      input logic       sck_now);
        frame_ok = (falls == `FRAME_BITS) && !bad_start && !sck_now;
    endfunction

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            csn_sync_reg <= 2'h3;
            sck_sync_reg <= 2'h0;
            csn_d_reg    <= 1'b1;
            sck_d_reg    <= 1'b0;
        end else begin
            csn_sync_reg <= {csn_sync_reg[0], csn_pin};
            sck_sync_reg <= {sck_sync_reg[0], sck_pin};
            csn_d_reg    <= csn_sync_reg[1];
            sck_d_reg    <= sck_sync_reg[1];
        end
    end

    assign csn_s    = csn_sync_reg[1];
    assign sck_s    = sck_sync_reg[1];
    assign csn_fall = csn_d_reg & ~csn_s;
    assign csn_rise = ~csn_d_reg & csn_s;
    assign sck_rise = ~sck_d_reg & sck_s & ~csn_s;  // RULE_01
    assign sck_fall = sck_d_reg & ~sck_s & ~csn_s;  // RULE_01

    assign port_on = ~track_mode & ~io_uv_flag & main_supply_power_on_threshold; // RULE_10 RULE_11

    // Operating mode follows the control input unless an under-voltage forces standby
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_reg <= status_spi_pkg::MODE_STANDBY;
        end else if (main_uv_flag || io_uv_flag) begin
            mode_reg <= status_spi_pkg::MODE_STANDBY; // RULE_17
        end else if (standby_control_input) begin
            mode_reg <= status_spi_pkg::MODE_NORMAL;  // RULE_18
        end else begin
            mode_reg <= status_spi_pkg::MODE_STANDBY; // RULE_18
        end
    end

    always_comb begin
        case (mode_reg)
            status_spi_pkg::MODE_NORMAL:  mode_is_normal = 1'b1;
            status_spi_pkg::MODE_STANDBY: mode_is_normal = 1'b0;
            default:                      mode_is_normal = 1'b0;
        endcase
    end
    assign normal_mode = mode_is_normal;

    // Under-voltage flags; a wake clears them, mode then follows the control input
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            main_uv_flag <= 1'b0;
        end else if (wake_flag) begin
            main_uv_flag <= 1'b0;                     // RULE_19
        end else begin
            main_uv_flag <= main_uv_detect;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            io_uv_flag <= 1'b0;
        end else if (wake_flag) begin
            io_uv_flag <= 1'b0;                       // RULE_19
        end else begin
            io_uv_flag <= io_uv_detect;
        end
    end

    // Frame length and select-edge checks
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fall_cnt_reg <= 6'h00;
        end else if (csn_fall) begin
            fall_cnt_reg <= 6'h00;
        end else if (sck_fall && fall_cnt_reg != 6'h3F) begin
            fall_cnt_reg <= fall_cnt_reg + 6'h01;     // RULE_05
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frame_bad_reg <= 1'b0;
        end else if (csn_fall) begin
            frame_bad_reg <= sck_s;                   // RULE_20
        end
    end

    // Frame error: set wins over clear, cleared by select fall or track mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frame_error_flag <= 1'b0;
        end else if (port_on && csn_rise && !frame_ok(fall_cnt_reg, frame_bad_reg, sck_s)) begin
            frame_error_flag <= 1'b1;                 // RULE_05 RULE_07 RULE_20
        end else if (csn_fall || track_mode) begin
            frame_error_flag <= 1'b0;                 // RULE_21
        end
    end

    assign live_flags = {frame_error_flag, io_uv_flag, main_uv_flag,
                         tx_timeout_flag, thermal_flag, bus_error_flag, power_on_flag};

    // Latched bits: set wins; cleared after a correct frame if flag inactive
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latched_status <= `LATCHED_RESET;
        end else if (port_on && csn_rise && frame_ok(fall_cnt_reg, frame_bad_reg, sck_s)) begin
            latched_status <= live_flags;             // RULE_06
        end else begin
            latched_status <= latched_status | live_flags; // RULE_14
        end
    end

    // Guardian pin sampled at the falling edge ending bit 2
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            guard_fb_reg <= 1'b0;
        end else if (sck_fall && fall_cnt_reg == 6'd2) begin
            guard_fb_reg <= guardian_enable_input;    // RULE_13
        end
    end

    always_comb begin
        word = 32'h0000_0000;
        word[`BIT_WAKE]     = wake_flag;              // RULE_12
        word[`BIT_MODE]     = mode_is_normal;         // RULE_12
        word[`BIT_TX_READY] = tx_ready_flag;          // RULE_12
        word[`BIT_GUARD_FB] = mode_is_normal & guard_fb_reg; // RULE_13
        word[`BIT_LATCH_HI:`BIT_LATCH_LO] = latched_status;
        word[14:11] = `UNUSED_BITS;                   // RULE_15
        word[`BIT_PARITY] = ^word[14:0];              // RULE_16
        word[23:16] = ANALOG_REV;                     // RULE_09
        word[31:24] = DIGITAL_REV;                    // RULE_08
    end

    // Shift index: bit 0 after select falls, next bit at each rising edge after the first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bit_idx_reg <= 5'h00;
        end else if (csn_fall) begin
            bit_idx_reg <= 5'h00;                     // RULE_04
        end else if (sck_rise && fall_cnt_reg != 6'h00) begin
            bit_idx_reg <= fall_cnt_reg[4:0];         // RULE_02 RULE_04 RULE_07
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sdo_o  <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= port_on & ~csn_s;               // RULE_01 RULE_10 RULE_11
            sdo_o  <= word[bit_idx_reg];              // RULE_02
        end
    end

endmodule
`default_nettype wire

// *** core/status_spi_map.svh ***
// Offsets, field positions, reset values and counts of the serial status port
`ifndef STATUS_SPI_MAP_SVH
`define STATUS_SPI_MAP_SVH

`define FRAME_BITS          6'd16
`define EXT_FRAME_BITS      6'd32
`define BIT_WAKE            0
`define BIT_MODE            1
`define BIT_TX_READY        2
`define BIT_GUARD_FB        3
`define BIT_LATCH_LO        4
`define BIT_LATCH_HI        10
`define BIT_FRAME_ERR       10
`define BIT_PARITY          15
`define UNUSED_BITS         4'hA
`define LATCHED_RESET       7'h01
`define RATE_MIN_BPS        10000
`define RATE_MAX_BPS        2000000

`endif

// *** core/status_spi_pkg.sv ***
// Types shared by the serial status port
package status_spi_pkg;
    typedef enum logic [1:0] {
        MODE_STANDBY = 2'b01,
        MODE_NORMAL  = 2'b10
    } op_mode_e;
endpackage

// *** tb/spi_host.sv ***
// Host-side serial read master model
`timescale 1ns/10ps
`default_nettype none
module spi_host (
    output logic      csn_pin,  // Chip select, active low
    output logic      sck_pin,  // Serial clock, idle low
    input  wire logic sdo_line  // Resolved data line
);
    initial begin
        csn_pin = 1'b1;
        sck_pin = 1'b0;
    end
    // Bit i is shifted at rise i+1; sample it late in the low phase after that rise
    task automatic xfer(input int n, input bit sck_bad, output logic [31:0] d);
        d = '0;
        csn_pin = 1'b0;
        #200;
        for (int i = 0; i < n; i++) begin
            sck_pin = 1'b1;
            #100 sck_pin = 1'b0;
            #90;
            d[i] = sdo_line;
            #10;
        end
        #100 sck_pin = sck_bad;
        #100 csn_pin = 1'b1;
        #100 sck_pin = 1'b0;
        #400;
    endtask
endmodule
`default_nettype wire

// *** tb/spi_status_checker_assertions.sv ***
// Concurrent checks on the serial status port
`timescale 1ns/10ps
`default_nettype none
module spi_status_checker (
    input wire logic       clk, rst_n, csn_pin, sck_pin, sdo_o, sdo_oe,
    input wire logic       standby_control_input, guardian_enable_input,
    input wire logic       track_mode, main_supply_power_on_threshold,
    input wire logic       wake_flag, tx_ready_flag, power_on_flag,
    input wire logic       bus_error_flag, thermal_flag, tx_timeout_flag,
    input wire logic       main_uv_detect, io_uv_detect, main_uv_flag,
    input wire logic       io_uv_flag, normal_mode, frame_error_flag,
    input wire logic [6:0] latched_status
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_oe_csn_high: assert property (csn_pin[*5] |-> !sdo_oe)
        else $error("data driven while deselected");
    a_sdo_hold_low: assert property ((!sck_pin && !csn_pin)[*8] ##1
        (sdo_oe && $past(sdo_oe)) |-> $stable(sdo_o))
        else $error("data moved without clock rise");
    a_off_track: assert property (track_mode[*4] |-> !sdo_oe)
        else $error("port active in track mode");
    a_off_io_uv: assert property (io_uv_flag[*4] |-> !sdo_oe)
        else $error("port active with io supply low");
    a_off_power: assert property (!main_supply_power_on_threshold[*4] |-> !sdo_oe)
        else $error("port active in power off");
    a_uv_standby: assert property ((main_uv_flag || io_uv_flag)[*2] |-> !normal_mode)
        else $error("normal mode under low supply");
    a_mode_follow: assert property ((!main_uv_flag && !io_uv_flag && !wake_flag
        && standby_control_input)[*3] |-> normal_mode)
        else $error("mode ignores standby control");
    a_wake_clears: assert property (wake_flag |=> !main_uv_flag && !io_uv_flag)
        else $error("wake left supply flags set");
    a_err_track: assert property (track_mode[*3] |-> !frame_error_flag)
        else $error("frame error kept in track mode");
    a_err_latch: assert property (frame_error_flag |-> ##[1:2] latched_status[6])
        else $error("frame error not latched");
    a_bus_latch: assert property (bus_error_flag |=> latched_status[1])
        else $error("bus error not latched");
    c_frame_err: cover property ($rose(frame_error_flag));
    c_cleared: cover property ($fell(latched_status[0]));
    c_oe_on: cover property ($rose(sdo_oe));
endmodule
bind status_register_spi_readout spi_status_checker spi_status_checker_inst (.*);
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the serial status port
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        clk, rst_n, sby, gua, trk, por, wake, txr, pon, berr, thm, tot, muv, iouv;
    logic        sdo_o, sdo_oe, m_uvf, io_uvf, nrm, ferr;
    logic [6:0]  lat;
    logic [31:0] d;
    wire logic   csn, sck, sdo_line;
    int          n_mismatch = 0;
    int          compares = 0;
    assign sdo_line = sdo_oe ? sdo_o : 1'bZ;
    spi_host spi_host_inst (.csn_pin(csn), .sck_pin(sck), .sdo_line(sdo_line));
    status_register_spi_readout #(.ANALOG_REV(8'h3C), .DIGITAL_REV(8'hC3))
        status_register_spi_readout_inst (.clk(clk), .rst_n(rst_n), .csn_pin(csn),
        .sck_pin(sck), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .standby_control_input(sby),
        .guardian_enable_input(gua), .track_mode(trk), .wake_flag(wake),
        .main_supply_power_on_threshold(por), .tx_ready_flag(txr), .power_on_flag(pon),
        .bus_error_flag(berr), .thermal_flag(thm), .tx_timeout_flag(tot),
        .main_uv_detect(muv), .io_uv_detect(iouv), .main_uv_flag(m_uvf),
        .io_uv_flag(io_uvf), .normal_mode(nrm), .frame_error_flag(ferr),
        .latched_status(lat));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Full frame; bits 14..11 read 1,0,1,0 and the latch clears afterwards
    task frame16(input logic [6:0] le, input logic g);
        logic [14:0] w;
        w = {4'hA, le, g, 3'b110};
        spi_host_inst.xfer(16, 1'b0, d);
        chk("word", d[15:0], {^w, w});
        wt(8);
        chk("latched", lat, 7'h00);
        chk("frame_err", ferr, 1'b0);
    endtask
    task t_ext;
        berr = 1'b1;
        wt(2);
        berr = 1'b0;
        spi_host_inst.xfer(32, 1'b0, d);
        chk("analog_rev", d[23:16], 8'h3C);
        chk("digital_rev", d[31:24], 8'hC3);
        wt(8);
        chk("frame_err", ferr, 1'b1);
        chk("latched", lat, 7'h42);
        gua = 1'b0;
        frame16(7'h42, 1'b0);
        $display("extended frame done");
    endtask
    task t_bad;
        spi_host_inst.xfer(15, 1'b0, d);
        wt(8);
        chk("frame_err", ferr, 1'b1);
        frame16(7'h40, 1'b0);
        spi_host_inst.xfer(16, 1'b1, d);
        wt(8);
        chk("frame_err", ferr, 1'b1);
        $display("bad frames done");
    endtask
    task t_off;
        trk = 1'b1;
        wt(4);
        chk("frame_err", ferr, 1'b0);
        spi_host_inst.xfer(16, 1'b0, d);
        chk("track_word", d, 32'h0000ZZZZ);
        trk = 1'b0;
        {muv, iouv} = 2'b11;
        wt(3);
        chk("uv_flags", {m_uvf, io_uvf, nrm}, 3'b110);
        spi_host_inst.xfer(16, 1'b0, d);
        chk("uv_word", d, 32'h0000ZZZZ);
        wake = 1'b1;
        wt(3);
        chk("uv_flags", {m_uvf, io_uvf}, 2'b00);
        {wake, muv, iouv} = 3'b000;
        wt(3);
        chk("mode", nrm, 1'b1);
        por = 1'b0;
        spi_host_inst.xfer(16, 1'b0, d);
        chk("por_word", d, 32'h0000ZZZZ);
        por = 1'b1;
        $display("port off cases done");
    endtask
    initial begin
        {rst_n, trk, wake, pon, berr, thm, tot, muv, iouv} = '0;
        {sby, gua, por, txr} = 4'hF;
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        wt(4);
        chk("latched_reset", lat, 7'h01);
        chk("oe_idle", sdo_oe, 1'b0);
        frame16(7'h01, 1'b1);
        $display("good frame done");
        t_ext();
        t_bad();
        t_off();
        end_sim();
    end
    initial begin
        #500000;
        n_mismatch++;
        end_sim();
    end
endmodule
`default_nettype wire
